// File: design/lps_fifo.sv
module lps_fifo
  import lps_pkg::*;
#(
  parameter int WIDTH = 1,
  parameter int DEPTH = 32
) (
  input  wire logic core_clk, // system clock
  input  wire logic rst,      // synchronous reset, high
  input  wire logic ce,       // clock enable
  lps_strm_if.snk   fill,     // write side
  lps_strm_if.src   drain,    // read side
  output wire logic full,     // no room left
  output wire logic empty     // nothing stored
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [PW:0]      count;

  // ---------------------------------------------------------------
  // handshakes
  // ---------------------------------------------------------------
  wire logic push = fill.valid & fill.ready;
  wire logic pop  = drain.valid & drain.ready;

  assign full        = (count == (PW+1)'(DEPTH));
  assign empty       = (count == '0);
  assign fill.ready  = ~full;
  assign drain.valid = ~empty;
  assign drain.data  = mem[rd_ptr];

  // storage, written by index; no reset needed on the data
  always_ff @(posedge core_clk) begin
    if (ce && push) begin
      mem[wr_ptr] <= fill.data;
    end
  end

  // pointers wrap at depth, which need not be a power of two
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else if (ce) begin
      if (push) begin
        wr_ptr <= (wr_ptr == PW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule // lps_fifo

// File: design/lps_loop_select.sv
`include "lps_map.svh"

module lps_loop_select
  import lps_pkg::*;
#(
  parameter int WORD_W = `LPS_WORD_W,
  parameter int DEPTH  = `LPS_FIFO_DEPTH
) (
  input  wire logic                   core_clk,     // 125 MHz clock
  input  wire logic                   rst,          // sync reset, high
  input  wire logic                   ce,           // clock enable
  // microprocessor register port
  input  wire logic [`LPS_ADDR_W-1:0] reg_addr,     // register address
  input  wire logic [7:0]             reg_wdata,    // write data
  input  wire logic                   reg_wr,       // write strobe
  input  wire logic                   reg_rd,       // read strobe
  output logic      [7:0]             reg_rdata,    // read data
  output logic                        reg_rvalid,   // read data valid
  // transmit framer stream
  input  wire logic                   txf_valid,    // framer word valid
  input  wire logic [WORD_W-1:0]      txf_data,     // framer word
  output logic                        txf_ready,    // fifo has room
  // line timing
  input  wire logic                   bit_slot,     // one word per slot
  // receive line pin
  input  wire logic [WORD_W-1:0]      rx_line_pin,  // raw line input
  // transmit line pin
  output logic      [WORD_W-1:0]      tx_line_data, // line output data
  output logic                        tx_line_oe,   // line driver on
  // receive framer stream
  output logic                        rxf_valid,    // word to framer
  output logic      [WORD_W-1:0]      rxf_data      // receive word
);

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  lps_byte_t framer_operating_mode;
  lps_byte_t transmit_redundancy_control;
  lps_byte_t line_interface_control;

  // ---------------------------------------------------------------
  // register decode
  // ---------------------------------------------------------------
  wire logic hit_fm = (reg_addr == `LPS_OFS_FRAMER_MODE);
  wire logic hit_tr = (reg_addr == `LPS_OFS_TX_REDUND);
  wire logic hit_lc = (reg_addr == `LPS_OFS_LINE_CTRL);
  wire logic hit_st = (reg_addr == `LPS_OFS_LOOP_STATUS);

  // register writes; read-only bits always hold zero
  always_ff @(posedge core_clk) begin
    if (rst) begin
      framer_operating_mode       <= `LPS_RST_FRAMER_MODE;
      transmit_redundancy_control <= `LPS_RST_TX_REDUND;
      line_interface_control      <= `LPS_RST_LINE_CTRL;
    end else if (ce && reg_wr) begin
      if (hit_fm) begin
        framer_operating_mode <= reg_wdata;
      end
      if (hit_tr) begin
        transmit_redundancy_control <= reg_wdata & `LPS_MASK_TX_REDUND;
      end
      if (hit_lc) begin
        line_interface_control <= reg_wdata & `LPS_MASK_LINE_CTRL;
      end
    end
  end

  // ---------------------------------------------------------------
  // mode decode
  // ---------------------------------------------------------------
  wire logic line_driver_on =
    transmit_redundancy_control[`LPS_TR_DRIVER_ON];
  wire logic remote_bit = line_interface_control[`LPS_LC_REMOTE_LOOP];
  wire logic local_bit  = line_interface_control[`LPS_LC_LOCAL_LOOP];
  wire logic framer_loop =
    framer_operating_mode[`LPS_FM_FRAMER_LOOP]; // RULE_15
  wire logic [1:0] timing_reference_select =
    framer_operating_mode[`LPS_FM_TIMREF_HI:`LPS_FM_TIMREF_LO];

  // analog loop lives in the analog front end, so it is normal here
  wire lps_line_mode_t line_mode =
    (remote_bit &  local_bit) ? LPS_LM_DIGITAL :     // RULE_01
    (remote_bit & ~local_bit) ? LPS_LM_REMOTE  :
    (local_bit)               ? LPS_LM_ANALOG  :
                                LPS_LM_NORMAL;       // RULE_16

  wire logic digital_loop = (line_mode == LPS_LM_DIGITAL);
  // remote loop only runs with the driver on
  wire logic remote_loop =
    (line_mode == LPS_LM_REMOTE) & line_driver_on;   // RULE_08

  // digital and framer loops need local timing; flag it for software, do not block it
  wire logic timing_warn = (digital_loop | framer_loop)
    & (timing_reference_select == `LPS_TIMREF_FREE); // RULE_04 RULE_14

  // ---------------------------------------------------------------
  // transmit framer buffer
  // ---------------------------------------------------------------
  lps_strm_if #(.WIDTH(WORD_W)) fifo_in  ();
  lps_strm_if #(.WIDTH(WORD_W)) fifo_out ();
  logic fifo_full;
  logic fifo_empty;

  assign fifo_in.valid = txf_valid;
  assign fifo_in.data  = txf_data;
  // drained one word per slot; during remote loop the word is
  // dropped so the framer keeps running rather than stalling
  assign fifo_out.ready = ce & bit_slot;

  lps_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .core_clk (core_clk),
    .rst      (rst),
    .ce       (ce),
    .fill     (fifo_in),
    .drain    (fifo_out),
    .full     (fifo_full),
    .empty    (fifo_empty)
  );

  // ---------------------------------------------------------------
  // receive pin synchroniser
  // ---------------------------------------------------------------
  logic [WORD_W-1:0] rx_meta;
  logic [WORD_W-1:0] rx_sync;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rx_meta <= '0;
      rx_sync <= '0;
    end else if (ce) begin
      rx_meta <= rx_line_pin;
      rx_sync <= rx_meta;
    end
  end

  // ---------------------------------------------------------------
  // path selection
  // ---------------------------------------------------------------
  logic [WORD_W-1:0] timing_out_q; // timing control stage output
  logic              timing_vld_q;

  // framer word, idle as zero when the buffer is empty
  wire logic [WORD_W-1:0] framer_word =
    fifo_out.valid ? fifo_out.data : '0;
  wire logic              framer_vld = bit_slot & fifo_out.valid;

  // recovery stage output: looped transmit or line input
  wire logic [WORD_W-1:0] cdr_out =
    digital_loop ? timing_out_q : rx_sync;      // RULE_02 RULE_03
  wire logic              cdr_vld =
    digital_loop ? timing_vld_q : bit_slot;

  // timing control input: recovered data or framer data
  wire logic [WORD_W-1:0] timing_in =
    remote_loop ? cdr_out : framer_word;        // RULE_05 RULE_07
  wire logic              timing_in_vld =
    remote_loop ? cdr_vld : framer_vld;

  // receive framer input: looped framer output or recovered data
  wire logic [WORD_W-1:0] next_rxf_data =
    framer_loop ? framer_word : cdr_out;   // RULE_10 RULE_12 RULE_06
  wire logic              next_rxf_valid =
    framer_loop ? framer_vld : cdr_vld;    // RULE_13

  // line copy gated by the driver; loops into receive are not
  wire logic [WORD_W-1:0] next_tx_line =
    line_driver_on ? timing_out_q : '0;    // RULE_11

  // ---------------------------------------------------------------
  // datapath registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      timing_out_q <= '0;
      timing_vld_q <= 1'b0;
    end else if (ce) begin
      timing_vld_q <= timing_in_vld;
      if (timing_in_vld) begin
        timing_out_q <= timing_in;
      end
    end
  end

  // all outputs straight from flops
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_line_data <= '0;
      tx_line_oe   <= 1'b0;
      rxf_data     <= '0;
      rxf_valid    <= 1'b0;
      txf_ready    <= 1'b0;
    end else if (ce) begin
      tx_line_data <= next_tx_line;
      tx_line_oe   <= line_driver_on;
      rxf_data     <= next_rxf_data;
      rxf_valid    <= next_rxf_valid;
      txf_ready    <= ~fifo_full;
    end
  end
  // note: txf_ready lags room by a cycle; the fifo refuses a push
  // when full, so a word sent against a stale ready is dropped

  // ---------------------------------------------------------------
  // register readback
  // ---------------------------------------------------------------
  wire lps_byte_t status_word = {
    2'h0,
    timing_warn,
    fifo_full,
    fifo_empty,
    framer_loop,
    line_mode
  };

  wire lps_byte_t next_rdata =
    hit_fm ? framer_operating_mode       :
    hit_tr ? transmit_redundancy_control :
    hit_lc ? line_interface_control      :
    hit_st ? status_word                 :
             `LPS_BYTE_ZERO;

  // unmapped reads answer zero, one cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (rst) begin
      reg_rdata  <= `LPS_BYTE_ZERO;
      reg_rvalid <= 1'b0;
    end else if (ce) begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= next_rdata;
      end
    end
  end

endmodule // lps_loop_select

// File: include/lps_map.svh
// Functional notes
// RULE_01: both loop bits one selects digital loop
// RULE_02: digital loop feeds timing output into recovery
// RULE_03: digital loop ignores line driver enable
// RULE_04: software sets local timing before digital loop
// RULE_05: remote loop feeds recovery into timing input
// RULE_06: remote loop still feeds receive framer
// RULE_07: remote loop discards transmit framer data
// RULE_08: remote loop broken while driver off
// RULE_09: software enables driver, then writes remote
// RULE_10: framer loop feeds transmit into receive framer
// RULE_11: framer loop line copy follows driver enable
// RULE_12: framer loop ignores receive line data
// RULE_13: framer loop works with driver off
// RULE_14: software sets local timing before framer loop
// RULE_15: bit seven enables the framer loop
// RULE_16: all loop bits zero gives normal paths
`ifndef LPS_MAP_SVH
`define LPS_MAP_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define LPS_ADDR_W          16
`define LPS_OFS_FRAMER_MODE 16'h1100
`define LPS_OFS_TX_REDUND   16'h1300
`define LPS_OFS_LINE_CTRL   16'h1306
`define LPS_OFS_LOOP_STATUS 16'h13f0

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define LPS_FM_FRAMER_LOOP  7
`define LPS_FM_TIMREF_HI    1
`define LPS_FM_TIMREF_LO    0
`define LPS_TR_DRIVER_ON    0
`define LPS_LC_REMOTE_LOOP  4
`define LPS_LC_LOCAL_LOOP   3
`define LPS_ST_TIMING_WARN  5
`define LPS_ST_FIFO_FULL    4
`define LPS_ST_FIFO_EMPTY   3
`define LPS_ST_FRAMER_LOOP  2
`define LPS_ST_MODE_HI      1
`define LPS_ST_MODE_LO      0

// ---------------------------------------------------------------
// reset values and masks
// ---------------------------------------------------------------
`define LPS_RST_FRAMER_MODE 8'h28
`define LPS_RST_TX_REDUND   8'h00
`define LPS_RST_LINE_CTRL   8'h00
`define LPS_MASK_TX_REDUND  8'h01
`define LPS_MASK_LINE_CTRL  8'h18
`define LPS_BYTE_ZERO       8'h00
`define LPS_TIMREF_FREE     2'h0

// ---------------------------------------------------------------
// fifo sizing
// ---------------------------------------------------------------
`define LPS_FIFO_DEPTH      32
`define LPS_WORD_W          1

`endif

// File: include/lps_pkg.sv
package lps_pkg;

  // ---------------------------------------------------------------
  // line-interface loop selection
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    LPS_LM_NORMAL,
    LPS_LM_ANALOG,
    LPS_LM_REMOTE,
    LPS_LM_DIGITAL
  } lps_line_mode_t;

  typedef logic [7:0] lps_byte_t;

endpackage

// File: include/lps_strm_if.sv
interface lps_strm_if #(parameter int WIDTH = 1);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;

  // producer drives valid and data, consumer drives ready
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// File: verification/lps_assertions.sv
`include "lps_map.svh"

module lps_assertions
  import lps_pkg::*;
#(
  parameter int WORD_W = 1,
  parameter int DEPTH  = 32
) (
  input wire logic                   core_clk,     // clock
  input wire logic                   rst,          // sync reset
  input wire logic                   ce,           // clock enable
  input wire logic [`LPS_ADDR_W-1:0] reg_addr,     // address
  input wire logic [7:0]             reg_wdata,    // write data
  input wire logic                   reg_wr,       // write strobe
  input wire logic                   reg_rd,       // read strobe
  input wire logic [7:0]             reg_rdata,    // read data
  input wire logic                   reg_rvalid,   // read valid
  input wire logic                   bit_slot,     // word strobe
  input wire logic [WORD_W-1:0]      tx_line_data, // line data
  input wire logic                   tx_line_oe,   // driver on
  input wire logic                   rxf_valid     // word to framer
);
  timeunit 1ns;
  timeprecision 100ps;

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  // decoded strobes; holes in the map must read back zero
  wire drv_wr = ce && reg_wr && reg_addr == `LPS_OFS_TX_REDUND;
  wire hole_rd = ce && reg_rd && reg_addr != `LPS_OFS_FRAMER_MODE
    && reg_addr != `LPS_OFS_TX_REDUND && reg_addr != `LPS_OFS_LINE_CTRL
    && reg_addr != `LPS_OFS_LOOP_STATUS;

  a_rd_answers: assert property (
    ce && reg_rd |=> reg_rvalid)
    else $error("read strobe got no valid");
  a_rvalid_needs_rd: assert property (
    reg_rvalid |-> $past(reg_rd))
    else $error("read valid without a read");
  // reset clears the read data, so it may move at that edge too
  a_rdata_holds: assert property (
    !$past(reg_rd) && !$past(rst) |-> $stable(reg_rdata))
    else $error("read data moved without a read");
  a_hole_reads_zero: assert property (
    hole_rd |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_driver_turns_on: assert property (
    drv_wr && reg_wdata[0] |-> ##[1:2] tx_line_oe)
    else $error("driver enable not applied");
  a_driver_turns_off: assert property (
    drv_wr && !reg_wdata[0] |-> ##[1:2] !tx_line_oe)
    else $error("driver disable not applied");
  // a mid-run reset also drops the driver enable
  a_oe_needs_write: assert property (
    $changed(tx_line_oe) |->
      $past(drv_wr) || $past(drv_wr, 2) || $past(rst))
    else $error("driver enable moved by itself");
  a_line_quiet_off: assert property (
    !tx_line_oe && !$past(tx_line_oe) |-> tx_line_data == '0)
    else $error("line data while driver off");
  a_rxf_after_slot: assert property (
    rxf_valid |->
      $past(bit_slot) || $past(bit_slot, 2) || $past(bit_slot, 3))
    else $error("receive word without a slot");
endmodule // lps_assertions

// File: verification/lps_line_far.sv
module lps_line_far #(
  parameter int WORD_W = 1
) (
  input  wire logic              core_clk,     // clock
  input  wire logic              bit_slot,     // word strobe
  input  wire logic [WORD_W-1:0] far_word,     // next word to send
  input  wire logic [WORD_W-1:0] tx_line_data, // device line output
  input  wire logic              tx_line_oe,   // device driver on
  output logic      [WORD_W-1:0] rx_line_pin,  // line toward device
  output int                     line_ones     // ones heard on line
);
  timeunit 1ns;
  timeprecision 100ps;

  initial rx_line_pin = '0;
  initial line_ones = 0;
  // remote end sends a word per slot, changing just after the edge;
  // it only listens while the device drives the line
  always @(posedge core_clk) begin
    if (bit_slot) begin
      rx_line_pin <= far_word;
      line_ones <= line_ones + int'(tx_line_oe && tx_line_data[0]);
    end
  end
endmodule // lps_line_far

// File: verification/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  logic        core_clk, rst, ce, reg_wr, reg_rd, reg_rvalid;
  logic        txf_valid, txf_ready, bit_slot, tx_line_oe, rxf_valid;
  logic [15:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata;
  logic [0:0]  txf_data, rx_line_pin, tx_line_data, rxf_data, far_word;
  int          fail_count, samples_checked, line_ones, seed = 72;
  int          fq[$];
  logic [0:0]  prev_far;
  // modes: [3:2] loop bits, [1] framer loop, [0] driver on
  logic [3:0]  modes[9] = '{4'h0, 4'h5, 4'h9, 4'h8, 4'hd, 4'hc,
                            4'h3, 4'h2, 4'h1};

  lps_loop_select #(.WORD_W(1), .DEPTH(32)) i_lps_loop_select (
    .core_clk(core_clk), .rst(rst), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .txf_valid(txf_valid), .txf_data(txf_data), .txf_ready(txf_ready),
    .bit_slot(bit_slot), .rx_line_pin(rx_line_pin),
    .tx_line_data(tx_line_data), .tx_line_oe(tx_line_oe),
    .rxf_valid(rxf_valid), .rxf_data(rxf_data));

  lps_line_far #(.WORD_W(1)) i_lps_line_far (
    .core_clk(core_clk), .bit_slot(bit_slot), .far_word(far_word),
    .tx_line_data(tx_line_data), .tx_line_oe(tx_line_oe),
    .rx_line_pin(rx_line_pin), .line_ones(line_ones));

  initial begin
    core_clk = 0;
    forever #4 core_clk = ~core_clk;
  end

  function automatic logic [0:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[0];
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // one register cycle; strobe taken at the second edge
  task automatic reg_op(input bit wr, input logic [15:0] a, logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= wr;
    reg_rd <= !wr;
    @(posedge core_clk);
    reg_wr <= 0;
    reg_rd <= 0;
  endtask

  task automatic reg_chk(input logic [15:0] a, input logic [7:0] e);
    reg_op(0, a, 8'h00);
    @(negedge core_clk);
    chk({7'h00, reg_rvalid}, 8'h01);
    chk(reg_rdata, e);
  endtask

  // one line slot; model pops the framer word the design pops
  task automatic slot(input bit push, input bit on, input logic [3:0] m);
    logic [0:0] w, pw, ef, et, got;
    int n;
    w = xs();
    @(posedge core_clk);
    bit_slot <= 1;
    txf_valid <= push;
    txf_data <= w;
    far_word <= xs();
    @(posedge core_clk);
    bit_slot <= 0;
    txf_valid <= 0;
    if (push) fq.push_back(w);
    pw = 1'(fq.pop_front());
    ef = (m[3:2] == 2'b11 || m[1]) ? pw : prev_far;
    et = !m[0] ? 1'b0 : (m[3:2] == 2'b10 ? prev_far : pw);
    n = 0;
    got = 0;
    repeat (3) begin
      @(negedge core_clk);
      if (rxf_valid === 1'b1) begin
        n++;
        got = rxf_data;
      end
    end
    prev_far = far_word;
    if (on) begin
      chk(8'(n), 8'h01);
      chk({7'h00, got}, {7'h00, ef});
      chk({6'h00, tx_line_oe, tx_line_data}, {6'h00, m[0], et});
    end
  endtask

  initial begin
    {rst, ce, reg_wr, reg_rd, txf_valid, bit_slot} = 6'h30;
    {reg_addr, reg_wdata, txf_data, far_word, prev_far} = '0;
    repeat (3) @(posedge core_clk);
    rst <= 0;
    reg_chk(16'h1100, 8'h28);
    reg_chk(16'h1300, 8'h00);
    reg_chk(16'h1306, 8'h00);
    reg_op(1, 16'h1306, 8'hff);
    reg_chk(16'h1306, 8'h18);
    reg_op(1, 16'h1300, 8'hff);
    reg_chk(16'h1300, 8'h01);
    reg_chk(16'h1200, 8'h00);
    reg_op(1, 16'h1306, 8'h00);
    // fill past the top; the last push must be dropped
    for (int i = 0; i < 33; i++) begin
      @(posedge core_clk);
      txf_valid <= 1;
      txf_data <= xs();
      #1 if (i < 32) fq.push_back(txf_data);
    end
    @(posedge core_clk);
    txf_valid <= 0;
    @(negedge core_clk);
    chk({7'h00, txf_ready}, 8'h00);
    reg_chk(16'h13f0, 8'h10);
    slot(0, 0, 4'h1);
    foreach (modes[k]) begin
      reg_op(1, 16'h1100, 8'h29);
      reg_op(1, 16'h1300, {7'h00, modes[k][0]});
      reg_op(1, 16'h1306, {3'h0, modes[k][3:2], 3'h0});
      reg_op(1, 16'h1100, {modes[k][1], 7'h29});
      // status shows the decoded loop bits; buffer holds 31 words
      reg_chk(16'h13f0, {5'h00, modes[k][1], modes[k][3:2]});
      repeat (2) slot(1, 0, modes[k]);
      repeat (4) slot(1, 1, modes[k]);
    end
    // drain to empty while checking the normal path
    repeat (31) slot(0, 1, 4'h1);
    reg_chk(16'h13f0, 8'h08);
    chk(8'(line_ones != 0), 8'h01);
    // framer loop on free-running timing is flagged, not blocked
    reg_op(1, 16'h1100, 8'h80);
    reg_chk(16'h13f0, 8'h2c);
    // a second reset mid-run must restore the reset state
    @(posedge core_clk);
    rst <= 1;
    @(posedge core_clk);
    rst <= 0;
    reg_chk(16'h1100, 8'h28);
    reg_chk(16'h1300, 8'h00);
    reg_chk(16'h13f0, 8'h08);
    chk({7'h00, tx_line_oe}, 8'h00);
    report_and_stop();
  end

  initial begin
    repeat (6000) @(posedge core_clk);
    fail_count++;
    report_and_stop();
  end
endmodule // tb_top

bind lps_loop_select lps_assertions #(.WORD_W(WORD_W), .DEPTH(DEPTH))
  i_lps_assertions (
  .core_clk(core_clk), .rst(rst), .ce(ce), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .bit_slot(bit_slot),
  .tx_line_data(tx_line_data), .tx_line_oe(tx_line_oe),
  .rxf_valid(rxf_valid));
